// ==== design/cct_charge_ctrl.sv ====
// Charge phase sequencer, limit selection and charge timers behind APB
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "cct_consts.svh"

module cct_charge_ctrl
#(
   parameter int unsigned TICK_CYCLES = `CCT_TICK_CYCLES
)
(
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  cct_pkg::cct_sense_s  sense,
   output cct_pkg::cct_limits_s limits,
   output logic              converter_enable,
   output logic              int_pulse,
   output logic [2:0]        charge_status,
   output logic [9:0]        lowv_permille,
   output logic [9:0]        rechg_permille
);
   import cct_pkg::*;

   // ==========================================================
   // Input synchroniser
   cct_sense_s sync1_q;
   cct_sense_s s;

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
      begin
         sync1_q <= '0;
         s       <= '0;
      end
      else
      begin
         sync1_q <= sense;
         s       <= sync1_q;
      end

   // ==========================================================
   // APB register file
   logic [31:0] ctrl_q;
   logic [31:0] lim_q;
   logic [31:0] thr_q;
   logic        fault_q;
   logic        cvexp_q;
   logic        wr_en;
   logic        setup;
   logic        hit;
   logic [31:0] rd_mux;
   cct_state_e  state_q;
   cct_state_e  state_d;
   logic [2:0]  status_q;

   assign setup  = psel & ~penable;
   assign wr_en  = psel & penable & pwrite;
   assign pready = psel & penable;

   always_comb
   begin
      hit    = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `CCT_OFS_CTRL:   rd_mux = ctrl_q;
         `CCT_OFS_LIMITS: rd_mux = lim_q;
         `CCT_OFS_THRESH: rd_mux = thr_q;
         `CCT_OFS_STATUS:
            rd_mux = {26'h000_0000, cvexp_q, fault_q, 1'b0, status_q};
         `CCT_OFS_EFFECT:
            rd_mux = {7'h00, limits.term_threshold,
                      7'h00, limits.charge_limit};
         default:         hit = 1'b0;
      endcase
   end

   // Read data and error caught in the setup cycle
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= ~hit;
      end

   // charge field resets to code 0x190 (400)
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
      begin
         ctrl_q <= `CCT_CTRL_RESET;
         lim_q  <= `CCT_LIM_RESET;
         thr_q  <= `CCT_THR_RESET;
      end
      else if (wr_en)
      begin
         if (paddr == `CCT_OFS_CTRL)
            ctrl_q <= pwdata & `CCT_CTRL_MASK;
         if (paddr == `CCT_OFS_LIMITS)
            lim_q <= pwdata & `CCT_LIM_MASK;
         if (paddr == `CCT_OFS_THRESH)
            thr_q <= pwdata & `CCT_THR_MASK;
      end

   logic       chg_en;
   logic       term_en;
   logic       pre_en;
   logic       safe_en;
   logic       half_en;
   logic       pin_en;
   logic       cv_mask;
   logic [1:0] topoff_sel;
   logic [8:0] charge_current_set_pin_field;
   logic [8:0] termination_current_field_field;
   logic [1:0] lowv_sel;
   logic [1:0] rechg_sel;
   logic [1:0] safe_sel;
   logic [3:0] cv_sel;

   assign chg_en      = ctrl_q[`CCT_CTRL_CHG_EN];
   assign term_en     = ctrl_q[`CCT_CTRL_TERM_EN];
   assign pre_en      = ctrl_q[`CCT_CTRL_PRE_EN];
   assign safe_en     = ctrl_q[`CCT_CTRL_SAFE_EN];
   assign half_en     = ctrl_q[`CCT_CTRL_HALF_EN];
   assign pin_en      = ctrl_q[`CCT_CTRL_PIN_EN];
   assign cv_mask     = ctrl_q[`CCT_CTRL_CV_MASK];
   assign topoff_sel  = ctrl_q[`CCT_CTRL_TOPOFF_LSB +: 2];
   assign charge_current_set_pin_field  = lim_q[`CCT_LIM_CHARGE_CURRENT_SET_PIN_LSB +: 9];
   assign termination_current_field_field = lim_q[`CCT_LIM_TERMINATION_CURRENT_FIELD_LSB +: 9];
   assign lowv_sel    = thr_q[`CCT_THR_LOWV_LSB +: 2];
   assign rechg_sel   = thr_q[`CCT_THR_RECHG_LSB +: 2];
   assign safe_sel    = thr_q[`CCT_THR_SAFE_LSB +: 2];
   assign cv_sel      = thr_q[`CCT_THR_CV_LSB +: 4];

   // ==========================================================
   // Limit selection
   logic [8:0] pin_max;
   logic [8:0] pin_tenth;
   assign pin_max   = pin_en ? s.pin_code : charge_current_set_pin_field;
   assign pin_tenth = pin_max / 9'd10;

   // recomputed every cycle from live fields
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         limits <= '0;
      else
      begin
         // pin ignored when its function is off
         limits.charge_limit <= (pin_en && s.pin_code < charge_current_set_pin_field) ?
                                s.pin_code : charge_current_set_pin_field;
         limits.precharge_limit <= pin_max / 9'd5;
         limits.term_threshold <= (pin_tenth < termination_current_field_field) ?
                                  pin_tenth : termination_current_field_field;
      end

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
      begin
         lowv_permille  <= 10'h000;
         rechg_permille <= 10'h000;
      end
      else
      begin
         case (lowv_sel)
            2'h0:    lowv_permille <= `CCT_LOWV_SEL0;
            2'h1:    lowv_permille <= `CCT_LOWV_SEL1;
            2'h2:    lowv_permille <= `CCT_LOWV_SEL2;
            default: lowv_permille <= `CCT_LOWV_SEL3;
         endcase
         case (rechg_sel)
            2'h0:    rechg_permille <= `CCT_RECHG_SEL0;
            2'h1:    rechg_permille <= `CCT_RECHG_SEL1;
            2'h2:    rechg_permille <= `CCT_RECHG_SEL2;
            default: rechg_permille <= `CCT_RECHG_SEL3;
         endcase
      end

   // ==========================================================
   // Time base and rate control
   logic [25:0] tick_cnt_q;
   logic        tick;
   logic        half_phase_q;
   logic        input_power_limiting;
   logic        halfrate;
   logic        adv;
   logic        cv_adv;

   assign tick = (tick_cnt_q == 26'(TICK_CYCLES - 1));
   assign input_power_limiting  = s.vin_limit_active | s.iin_limit_active;
   // full rate when doubling is off
   assign halfrate = half_en & (input_power_limiting | s.temp_current_reduced);
   // half rate takes every second tick
   assign adv    = tick & ~s.charge_fault & (~halfrate | half_phase_q);
   // paused on faults and input limiting
   assign cv_adv = tick & ~s.charge_fault & ~input_power_limiting & s.cv_regulation;

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         tick_cnt_q <= 26'h000_0000;
      else
         tick_cnt_q <= tick ? 26'h000_0000 : tick_cnt_q + 26'h000_0001;

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         half_phase_q <= 1'b0;
      else if (!halfrate)
         half_phase_q <= 1'b0;
      else if (tick)
         half_phase_q <= ~half_phase_q;

   // ==========================================================
   // Timers: 0 safety, 1 pre-charge, 2 top-off, 3 CV
   logic [3:0]  t_run;
   logic [3:0]  t_step;
   logic [3:0]  t_exp;
   logic [16:0] t_lim [4];
   logic [16:0] safe_lim;
   logic        chg_phase;

   assign chg_phase = state_q inside {CCT_TRICKLE, CCT_PRE, CCT_CC, CCT_CV};

   always_comb
      case (safe_sel)
         2'h0:    safe_lim = 17'(`CCT_SAFE_SEL0_S);
         2'h1:    safe_lim = 17'(`CCT_SAFE_SEL1_S);
         2'h2:    safe_lim = 17'(`CCT_SAFE_SEL2_S);
         default: safe_lim = 17'(`CCT_SAFE_SEL3_S);
      endcase

   // enable bit gates the safety timer
   assign t_run[0]  = chg_phase & safe_en;
   assign t_step[0] = adv;
   assign t_lim[0]  = safe_lim;
   assign t_run[1]  = (state_q inside {CCT_TRICKLE, CCT_PRE}) & pre_en;
   assign t_step[1] = adv;
   assign t_lim[1]  = 17'(`CCT_PRECHG_S);
   // top-off follows safety pausing and doubling
   assign t_run[2]  = (state_q == CCT_TOPOFF);
   assign t_step[2] = adv;
   assign t_lim[2]  = 17'(topoff_sel) * 17'(`CCT_TOPOFF_STEP_S);
   // CV timer from its field, zero disables
   assign t_run[3]  = (state_q == CCT_CV) & (cv_sel != 4'h0);
   assign t_step[3] = cv_adv;
   assign t_lim[3]  = 17'(cv_sel) * 17'(`CCT_CV_STEP_S);

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_tmr
         logic [16:0] cnt_q;
         assign t_exp[gi] = t_run[gi] & t_step[gi] &
                            (cnt_q == t_lim[gi] - 17'h0_0001);
         // cleared whenever the timer is not running
         always_ff @(posedge core_clk or posedge reset)
            if (reset)
               cnt_q <= 17'h0_0000;
            else if (!t_run[gi])
               cnt_q <= 17'h0_0000;
            else if (t_step[gi])
               cnt_q <= cnt_q + 17'h0_0001;
      end
   endgenerate

   // ==========================================================
   // Charge phase sequencer
   logic       cycle_ok;
   logic       term_hit;
   cct_state_e start_st;
   cct_state_e finish_st;
   logic [2:0] status_d;

   assign cycle_ok = chg_en & ~s.ce_n & ~fault_q;
   assign term_hit = term_en & ~input_power_limiting & s.vfb_above_rechg & s.ibat_below_term;
   assign finish_st = (topoff_sel != 2'h0) ? CCT_TOPOFF : CCT_DONE;

   always_comb
      if (pre_en && s.vfb_below_short)
         start_st = CCT_TRICKLE;
      else if (pre_en && s.vfb_below_lowv)
         start_st = CCT_PRE;
      else
         start_st = CCT_CC;

   always_comb
   begin
      state_d = state_q;
      if (!cycle_ok || t_exp[0] || t_exp[1])
         state_d = CCT_IDLE;
      else
         case (state_q)
            CCT_IDLE:
               if (!s.charge_fault)
                  state_d = start_st;
            CCT_TRICKLE:
               if (!pre_en || !s.vfb_below_short)
                  state_d = pre_en ? CCT_PRE : CCT_CC;
            CCT_PRE:
               if (!pre_en || !s.vfb_below_lowv)
                  state_d = CCT_CC;
            CCT_CC:
               if (term_hit)
                  state_d = finish_st;
               else if (s.cv_regulation)
                  state_d = CCT_CV;
            CCT_CV:
               if (term_hit)
                  state_d = finish_st;
               else if (t_exp[3])
                  state_d = CCT_DONE;
            CCT_TOPOFF:
               if (t_exp[2])
                  state_d = CCT_DONE;
            CCT_DONE:
               if (!s.vfb_above_rechg)
                  state_d = start_st;
            default:
               state_d = CCT_IDLE;
         endcase
   end

   always_comb
      case (state_d)
         CCT_TRICKLE: status_d = 3'h1;
         CCT_PRE:     status_d = 3'h2;
         CCT_CC:      status_d = 3'h3;
         CCT_CV:      status_d = 3'h4;
         CCT_TOPOFF:  status_d = 3'h6;
         CCT_DONE:    status_d = 3'h7;
         default:     status_d = 3'h0;
      endcase

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
      begin
         state_q  <= CCT_IDLE;
         status_q <= 3'h0;
      end
      else
      begin
         state_q  <= state_d;
         status_q <= status_d;
      end

   assign charge_status = status_q;

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         converter_enable <= 1'b0;
      else
         converter_enable <= ~s.charge_fault &
            (state_d inside {CCT_TRICKLE, CCT_PRE, CCT_CC, CCT_CV,
                             CCT_TOPOFF});

   // pulse on status change and timer events
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         int_pulse <= 1'b0;
      else
         int_pulse <= (status_d != status_q) | t_exp[0] | t_exp[1] |
                      (t_exp[3] & ~cv_mask);

   // fault flag, set wins over clear
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
      begin
         fault_q <= 1'b0;
         cvexp_q <= 1'b0;
      end
      else
      begin
         if (t_exp[0] || t_exp[1])
            fault_q <= 1'b1;
         else if (!chg_en || s.ce_n || (wr_en &&
                  paddr == `CCT_OFS_STATUS && pwdata[`CCT_STAT_FAULT]))
            fault_q <= 1'b0;
         if (t_exp[3])
            cvexp_q <= 1'b1;
         else if (wr_en && paddr == `CCT_OFS_STATUS &&
                  pwdata[`CCT_STAT_CVEXP])
            cvexp_q <= 1'b0;
      end

   // ==========================================================
   // Checks

   // Whether the previous tick advanced the timers
   logic last_adv_q;

   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         last_adv_q <= 1'b0;
      else if (tick)
         last_adv_q <= adv;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   chk_lim_lower: assert property (
      pin_en |=> limits.charge_limit <= $past(charge_current_set_pin_field) &&
                 limits.charge_limit <= $past(s.pin_code))
      else $error("charge limit above pin or register");
   chk_pin_off: assert property (
      !pin_en |=> limits.charge_limit == $past(charge_current_set_pin_field))
      else $error("pin limit used while pin disabled");
   chk_pre_fifth: assert property (
      pin_en |=> limits.precharge_limit == $past(s.pin_code) / 9'd5)
      else $error("pre-charge limit not one fifth");
   chk_term_lower: assert property (
      1'b1 |=> limits.term_threshold <= $past(termination_current_field_field))
      else $error("termination threshold above field");
   chk_done_off: assert property (
      state_q == CCT_DONE |-> !converter_enable && charge_status == 3'h7)
      else $error("converter on or bad status when done");
   chk_status_int: assert property (
      status_q != $past(status_q) |-> int_pulse)
      else $error("status change without interrupt");
   chk_dpm_noterm: assert property (
      (state_q == CCT_CV && input_power_limiting && !t_exp[3] && cycle_ok)
      |=> !(state_q inside {CCT_TOPOFF, CCT_DONE}))
      else $error("termination during input limiting");
   chk_topoff_code: assert property (
      state_q == CCT_TOPOFF |-> charge_status == 3'h6)
      else $error("top-off status code wrong");
   chk_safe_fault: assert property (
      t_exp[0] |=> fault_q && int_pulse && state_q == CCT_IDLE)
      else $error("safety expiry not reported");
   chk_cv_int: assert property (
      (t_exp[3] && !cv_mask) |=> int_pulse ##1 cvexp_q)
      else $error("CV expiry interrupt missing");
   chk_step_tick: assert property (
      adv |-> tick && !(halfrate && last_adv_q))
      else $error("timer advanced off tick or on two ticks at half rate");

   cov_done:    cover property (state_q == CCT_CV ##[1:1000] state_q == CCT_DONE);
   cov_topoff:  cover property (state_q == CCT_TOPOFF);
   cov_fault:   cover property (t_exp[0]);
   cov_rechg:   cover property (state_q == CCT_DONE ##1 state_q == CCT_CC);

endmodule

// ==== design/cct_consts.svh ====
// Constants for the charge-cycle timer control block
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH

// Time base
`define CCT_CLK_PERIOD_NS   20
`define CCT_TICK_PERIOD_NS  1000000000
`define CCT_TICK_CYCLES     (`CCT_TICK_PERIOD_NS / `CCT_CLK_PERIOD_NS)

// Register byte offsets
`define CCT_OFS_CTRL        8'h00
`define CCT_OFS_LIMITS      8'h04
`define CCT_OFS_THRESH      8'h08
`define CCT_OFS_STATUS      8'h0C
`define CCT_OFS_EFFECT      8'h10

// Control register fields
`define CCT_CTRL_CHG_EN     0
`define CCT_CTRL_TERM_EN    1
`define CCT_CTRL_PRE_EN     2
`define CCT_CTRL_SAFE_EN    3
`define CCT_CTRL_HALF_EN    4
`define CCT_CTRL_PIN_EN     5
`define CCT_CTRL_CV_MASK    6
`define CCT_CTRL_TOPOFF_LSB 8
`define CCT_CTRL_MASK       32'h0000_037F
`define CCT_CTRL_RESET      32'h0000_003F

// Limits register fields (50 mA per code)
`define CCT_LIM_CHARGE_CURRENT_SET_PIN_LSB    0
`define CCT_LIM_TERMINATION_CURRENT_FIELD_LSB   16
`define CCT_LIM_MASK        32'h01FF_01FF
`define CCT_LIM_RESET       32'h0014_0190

// Threshold and timer selection fields
`define CCT_THR_LOWV_LSB    0
`define CCT_THR_RECHG_LSB   4
`define CCT_THR_SAFE_LSB    8
`define CCT_THR_CV_LSB      12
`define CCT_THR_MASK        32'h0000_F333
`define CCT_THR_RESET       32'h0000_0233

// Status register fields
`define CCT_STAT_FAULT      4
`define CCT_STAT_CVEXP      5

// Threshold ratios in permille of the feedback target
`define CCT_LOWV_SEL0       10'h258
`define CCT_LOWV_SEL1       10'h226
`define CCT_LOWV_SEL2       10'h29B
`define CCT_LOWV_SEL3       10'h2CA
`define CCT_RECHG_SEL0      10'h3A2
`define CCT_RECHG_SEL1      10'h3B2
`define CCT_RECHG_SEL2      10'h3C1
`define CCT_RECHG_SEL3      10'h3D0

// Timer durations in seconds
`define CCT_SAFE_SEL0_S     18000
`define CCT_SAFE_SEL1_S     28800
`define CCT_SAFE_SEL2_S     43200
`define CCT_SAFE_SEL3_S     86400
`define CCT_PRECHG_S        7200
`define CCT_TOPOFF_STEP_S   900
`define CCT_CV_STEP_S       3600

`endif

// ==== design/cct_pkg.sv ====
// Types for the charge-cycle timer control block
package cct_pkg;

   typedef enum logic [6:0] {
      CCT_IDLE    = 7'b000_0001,
      CCT_TRICKLE = 7'b000_0010,
      CCT_PRE     = 7'b000_0100,
      CCT_CC      = 7'b000_1000,
      CCT_CV      = 7'b001_0000,
      CCT_TOPOFF  = 7'b010_0000,
      CCT_DONE    = 7'b100_0000
   } cct_state_e;

   typedef struct packed {
      logic       ce_n;
      logic [8:0] pin_code;
      logic       vfb_below_short;
      logic       vfb_below_lowv;
      logic       vfb_above_rechg;
      logic       ibat_below_term;
      logic       cv_regulation;
      logic       vin_limit_active;
      logic       iin_limit_active;
      logic       temp_current_reduced;
      logic       charge_fault;
   } cct_sense_s;

   typedef struct packed {
      logic [8:0] charge_limit;
      logic [8:0] precharge_limit;
      logic [8:0] term_threshold;
   } cct_limits_s;

endpackage

// ==== tb/cct_power_model.sv ====
// Battery and power stage model that drives the sense inputs
`timescale 1ns/1ps
module cct_power_model
(
   input  wire logic           core_clk,
   input  wire logic           reset,
   input  wire logic           converter_enable,
   input  cct_pkg::cct_sense_s base,
   output cct_pkg::cct_sense_s sense
);
   import cct_pkg::*;
   logic [5:0] lvl_q;

   // ==========================================
   // Battery level climbs while charged, drains when off
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         lvl_q <= 6'h00;
      else if (converter_enable && lvl_q != 6'h3F)
         lvl_q <= lvl_q + 6'h01;
      else if (!converter_enable && lvl_q != 6'h00)
         lvl_q <= lvl_q - 6'h01;
   end

   // ==========================================
   // Comparator flags from the level
   always_comb
   begin
      sense = base;
      sense.vfb_below_short = lvl_q < 6'h08;
      sense.vfb_below_lowv = lvl_q < 6'h10;
      sense.cv_regulation = lvl_q >= 6'h18;
      sense.vfb_above_rechg = lvl_q >= 6'h20;
      sense.ibat_below_term = lvl_q >= 6'h28;
   end
endmodule

// ==== tb/test_cct_charge_ctrl.sv ====
// Self-checking bench for the charge-cycle timer control block
`timescale 1ns/1ps
module test_cct_charge_ctrl;
   import cct_pkg::*;
   logic        core_clk;
   logic        reset;
   logic        psel, penable, pwrite, pready, pslverr, slv_q;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic        converter_enable, int_pulse;
   logic [2:0]  charge_status;
   logic [2:0]  last_q = 3'h0;
   logic [9:0]  lowv_permille, rechg_permille;
   cct_sense_s  base, sense;
   cct_limits_s limits;
   int          fail_count = 0;
   int          check_count = 0;
   int          n_int = 0;
   int          n_chg = 0;
   int          i0, c0;

   cct_charge_ctrl #(.TICK_CYCLES(1)) cct_charge_ctrl_inst
   (
      .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .sense, .limits, .converter_enable,
      .int_pulse, .charge_status, .lowv_permille, .rechg_permille
   );
   cct_power_model cct_power_model_inst
   (
      .core_clk, .reset, .converter_enable, .base, .sense
   );

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ==========================================
   // Event counters
   always @(posedge core_clk)
   begin
      if (int_pulse === 1'b1)
         n_int++;
      if (charge_status !== last_q)
         n_chg++;
      last_q <= charge_status;
   end

   // ==========================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
         @(posedge core_clk);
      while (pready !== 1'b1);
      rd_q = prdata;
      slv_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rd_q, e);
   endtask

   task automatic wait_st(input logic [2:0] s, input int n);
      for (int i = 0; i < n && charge_status !== s; i++)
         @(posedge core_clk);
      check(32'(charge_status), 32'(s));
   endtask

   task automatic finish_test();
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge core_clk);
      fail_count++;
      finish_test();
   end

   // ==========================================
   // Test sequence
   initial
   begin
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      base = '0;
      base.ce_n = 1'b1;
      base.pin_code = 9'h064;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      rd_chk(8'h00, 32'h0000_003F);
      rd_chk(8'h04, 32'h0014_0190);
      rd_chk(8'h08, 32'h0000_0233);
      rd_chk(8'h20, 32'h0000_0000);
      check(32'(slv_q), 32'h0000_0001);
      // Limit selection without restart
      check(32'(limits.charge_limit), 32'h0000_0064);
      check(32'(limits.precharge_limit), 32'h0000_0014);
      check(32'(limits.term_threshold), 32'h0000_000A);
      apb(1'b1, 8'h04, 32'h0005_0190);
      repeat (4) @(posedge core_clk);
      check(32'(limits.term_threshold), 32'h0000_0005);
      rd_chk(8'h10, 32'h0005_0064);
      apb(1'b1, 8'h00, 32'h0000_001F);
      repeat (4) @(posedge core_clk);
      check(32'(limits.charge_limit), 32'h0000_0190);
      apb(1'b1, 8'h00, 32'h0000_003F);
      apb(1'b1, 8'h04, 32'h0014_0050);
      repeat (4) @(posedge core_clk);
      check(32'(limits.charge_limit), 32'h0000_0050);
      // Threshold ratios
      apb(1'b1, 8'h08, 32'h0000_0203);
      repeat (3) @(posedge core_clk);
      check(32'(lowv_permille), 32'h0000_02CA);
      check(32'(rechg_permille), 32'h0000_03A2);
      apb(1'b1, 8'h08, 32'h0000_0231);
      repeat (3) @(posedge core_clk);
      check(32'(lowv_permille), 32'h0000_0226);
      check(32'(rechg_permille), 32'h0000_03D0);
      // Full cycle with top-off, termination and recharge
      apb(1'b1, 8'h00, 32'h0000_013F);
      i0 = n_int;
      c0 = n_chg;
      base.ce_n <= 1'b0;
      wait_st(3'b001, 50);
      wait_st(3'b010, 50);
      wait_st(3'b011, 50);
      wait_st(3'b100, 50);
      wait_st(3'b110, 50);
      repeat (850) @(posedge core_clk);
      check(32'(charge_status), 32'h0000_0006);
      wait_st(3'b111, 100);
      repeat (3) @(posedge core_clk);
      check(32'(converter_enable), 32'h0000_0000);
      check(n_int - i0, n_chg - c0);
      check(n_chg - c0, 32'h0000_0006);
      wait_st(3'b011, 100);
      // CV timer with termination off
      base.ce_n <= 1'b1;
      wait_st(3'b000, 50);
      apb(1'b1, 8'h00, 32'h0000_003D);
      apb(1'b1, 8'h08, 32'h0000_1233);
      base.ce_n <= 1'b0;
      wait_st(3'b100, 200);
      repeat (3000) @(posedge core_clk);
      check(32'(charge_status), 32'h0000_0004);
      wait_st(3'b111, 1000);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check(32'(rd_q[5]), 32'h0000_0001);
      // Safety timer at half then full rate
      base.ce_n <= 1'b1;
      wait_st(3'b000, 50);
      apb(1'b1, 8'h00, 32'h0000_003F);
      apb(1'b1, 8'h08, 32'h0000_0033);
      base.iin_limit_active <= 1'b1;
      base.ce_n <= 1'b0;
      wait_st(3'b100, 200);
      repeat (100) @(posedge core_clk);
      check(32'(charge_status), 32'h0000_0004);
      apb(1'b1, 8'h00, 32'h0000_003D);
      repeat (20000) @(posedge core_clk);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check(32'(rd_q[4]), 32'h0000_0000);
      base.iin_limit_active <= 1'b0;
      repeat (9000) @(posedge core_clk);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      check(32'(rd_q[4]), 32'h0000_0001);
      finish_test();
   end
endmodule
